// [rtl/dpmc_host.sv]
// Purpose: Host controller driving one port of an async dual-port memory
// Assumes: 10 MHz core clock, one request at a time
// Notes:   Memory and flag accesses; pin combinations kept legal
// How it works
// - Wide words use one primary and secondary devices, no extra logic.
// - Select low plus read_write low writes; read_write high and drive low reads.
// - Flag select low, port select high, drive low reads a lock flag.
// - Rising read_write edge with flag select low writes byte line 0 to flag.
// - Location bits 2 to 0 pick the lock flag.
`timescale 1ns/1ns
`include "dpmc_params.svh"
module dpmc_host (
    // Clock, reset, enable
    input  wire logic                       core_clk_i,
    input  wire logic                       nrst_i,
    input  wire logic                       ce_i,
    // User request
    input  wire logic                       req_valid_i,
    input  wire dpmc_pkg::dpmc_req_t        req_i,
    output logic                            req_ready_o,
    output logic                            rsp_valid_o,
    output logic [`DPMC_DATA_W-1:0]         rsp_data_o,
    // Device port pins
    output dpmc_pkg::dpmc_pins_t            pins_o,
    input  wire logic [`DPMC_DATA_W-1:0]    byte_lines_i,
    input  wire logic                       collision_wait_n_i,
    input  wire logic                       port_message_flag_n_i,
    output logic                            collision_wait_n_o,
    output logic                            msg_flag_n_o
);
    // ----------------------------------------------------------------
    // Reset release
    // ----------------------------------------------------------------
    logic [1:0] rst_sync_reg;
    logic       rst_n;

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    // Everything below is reset by the released copy
    assign rst_n = rst_sync_reg[1];

    // ----------------------------------------------------------------
    // Pin input synchronisers
    // ----------------------------------------------------------------
    logic [`DPMC_DATA_W+1:0] sync_q;

    // Flag pins enter inverted, so a cleared synchroniser reads as idle high
    dpmc_sync #(
        .W          (`DPMC_DATA_W + 2)
    ) u_sync (
        .core_clk_i (core_clk_i),
        .rst_n_i    (rst_n),
        .ce_i       (ce_i),
        .d_i        ({~collision_wait_n_i, ~port_message_flag_n_i, byte_lines_i}),
        .q_o        (sync_q)
    );

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    function automatic logic is_flag_op(input logic [1:0] op);
        return op[1];
    endfunction : is_flag_op

    function automatic logic is_write_op(input logic [1:0] op);
        return op[0];
    endfunction : is_write_op

    dpmc_pkg::dpmc_state_t      state_reg, state_next;
    dpmc_pkg::dpmc_req_t        cur_reg;
    dpmc_pkg::dpmc_req_t        act_req;
    logic [`DPMC_CNT_W-1:0]     cnt_reg;
    dpmc_pkg::dpmc_pins_t       pins_next;
    logic                       take;
    logic                       cnt_done;
    logic                       cur_flag;
    logic                       cur_wr;
    logic [`DPMC_DATA_W-1:0]    flag_read;

    // Ready stays low until the first enabled edge after reset
    assign take      = (state_reg == dpmc_pkg::DPMC_IDLE) && req_ready_o && req_valid_i;
    // Strobe length in cycles, at least one
    assign cnt_done  = (cnt_reg == `DPMC_CNT_W'(`DPMC_STROBE_CYC - 1));
    // Request in service; at the taking edge it is still on the input
    assign act_req   = take ? req_i : cur_reg;
    assign cur_flag  = is_flag_op(act_req.op);
    assign cur_wr    = is_write_op(act_req.op);
    // Flag reads show the flag on every byte line
    assign flag_read = sync_q[`DPMC_DATA_W-1:0];

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    always_comb begin
        // Setup and done last one cycle; idle waits for a request, strobe for the count
        state_next = state_reg;
        unique case (state_reg)
            dpmc_pkg::DPMC_IDLE:   if (take) state_next = dpmc_pkg::DPMC_SETUP;
            dpmc_pkg::DPMC_SETUP:  state_next = dpmc_pkg::DPMC_STROBE;
            dpmc_pkg::DPMC_STROBE: if (cnt_done) state_next = dpmc_pkg::DPMC_DONE;
            dpmc_pkg::DPMC_DONE:   state_next = dpmc_pkg::DPMC_IDLE;
            default:               state_next = dpmc_pkg::DPMC_IDLE;
        endcase
    end

    // ----------------------------------------------------------------
    // Pin levels per state
    // ----------------------------------------------------------------
    always_comb begin
        // Idle: deselected, both selects high, outputs off
        // Location and byte lines hold while idle
        pins_next = '{port_select_n: 1'b1, read_write_select: 1'b1,
                      output_drive_enable_n: 1'b1, flag_space_select_n: 1'b1,
                      word_location: pins_o.word_location,
                      byte_lines: pins_o.byte_lines, byte_lines_oe: 1'b0};
        if (state_next != dpmc_pkg::DPMC_IDLE) begin
            pins_next.word_location = act_req.addr;
            if (cur_flag) begin
                // Never both selects low on the port
                pins_next.flag_space_select_n = 1'b0;
                pins_next.word_location = {{(`DPMC_ADDR_W-`DPMC_FLAG_IDX_W){1'b0}},
                                           act_req.addr[`DPMC_FLAG_IDX_W-1:0]};
                if (cur_wr) begin
                    // Low in strobe, high in done gives the rising edge
                    pins_next.read_write_select =
                        (state_next != dpmc_pkg::DPMC_STROBE);
                    pins_next.byte_lines = {{(`DPMC_DATA_W-1){1'b0}},
                                            act_req.wdata[0]};
                    pins_next.byte_lines_oe = 1'b1;
                end else begin
                    pins_next.output_drive_enable_n = 1'b0;
                end
            end else if (cur_wr) begin
                // Select low in strobe only, so location and data settle first
                pins_next.port_select_n = (state_next != dpmc_pkg::DPMC_STROBE);
                pins_next.read_write_select = pins_next.port_select_n;
                pins_next.byte_lines = act_req.wdata;
                pins_next.byte_lines_oe = 1'b1;
            end else begin
                // Select low from setup, so the byte crosses two flops by done
                pins_next.port_select_n = (state_next == dpmc_pkg::DPMC_DONE);
                pins_next.output_drive_enable_n = 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= dpmc_pkg::DPMC_IDLE;
            cur_reg   <= '0;
            cnt_reg   <= '0;
        end else if (ce_i) begin
            state_reg <= state_next;
            if (take) begin
                cur_reg <= req_i;
            end
            // Cycles spent in strobe
            cnt_reg <= (state_reg == dpmc_pkg::DPMC_STROBE) ? cnt_reg + 1'b1 : '0;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            pins_o <= '{port_select_n: 1'b1, read_write_select: 1'b1,
                        output_drive_enable_n: 1'b1, flag_space_select_n: 1'b1,
                        word_location: '0, byte_lines: '0, byte_lines_oe: 1'b0};
        end else if (ce_i) begin
            // Pins move only on an edge, so no glitch reaches the device
            pins_o <= pins_next;
        end
    end

    // ----------------------------------------------------------------
    // Response
    // ----------------------------------------------------------------
    // Read byte is driven from setup; two flops later it is taken at done
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            req_ready_o <= 1'b0;
            rsp_valid_o <= 1'b0;
            rsp_data_o  <= '0;
        end else if (ce_i) begin
            // Ready drops at the taking edge and returns with the response
            req_ready_o <= (state_next == dpmc_pkg::DPMC_IDLE) && !take;
            rsp_valid_o <= (state_reg == dpmc_pkg::DPMC_DONE);
            if (state_reg == dpmc_pkg::DPMC_DONE) begin
                // Writes answer with zero
                rsp_data_o <= cur_wr ? '0 : flag_read;
            end
        end
    end

    // ----------------------------------------------------------------
    // Device flag copies
    // ----------------------------------------------------------------
    // Device keeps these pins driven; the synchroniser holds them inverted
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            collision_wait_n_o <= 1'b1;
            msg_flag_n_o       <= 1'b1;
        end else if (ce_i) begin
            collision_wait_n_o <= !sync_q[`DPMC_DATA_W+1];
            msg_flag_n_o       <= !sync_q[`DPMC_DATA_W];
        end
    end

    // Primary/secondary strap and wide words are board wiring
endmodule : dpmc_host

// [rtl/dpmc_params.svh]
// Purpose: Constants for the dual-port memory host controller
// Assumes: 10 MHz core clock
// Notes:   Timing counts are whole core clock cycles
`ifndef DPMC_PARAMS_SVH
`define DPMC_PARAMS_SVH

`define DPMC_ADDR_W        13
`define DPMC_DATA_W        8
`define DPMC_FLAG_IDX_W    3
`define DPMC_STROBE_NS     100
`define DPMC_CLK_NS        100
`define DPMC_STROBE_CYC    ((`DPMC_STROBE_NS + `DPMC_CLK_NS - 1) / `DPMC_CLK_NS)
`define DPMC_CNT_W         4
`define DPMC_OP_READ       2'h0
`define DPMC_OP_WRITE      2'h1
`define DPMC_OP_FLAG_RD    2'h2
`define DPMC_OP_FLAG_WR    2'h3

`endif

// [rtl/dpmc_pkg.sv]
// Purpose: Types for the dual-port memory host controller
// Assumes: dpmc_params.svh is on the include path
// Notes:   Pin bundle and request carrier
`include "dpmc_params.svh"
package dpmc_pkg;

    typedef struct packed {
        logic [1:0]                 op;
        logic [`DPMC_ADDR_W-1:0]    addr;
        logic [`DPMC_DATA_W-1:0]    wdata;
    } dpmc_req_t;

    typedef struct packed {
        logic                       port_select_n;
        logic                       read_write_select;
        logic                       output_drive_enable_n;
        logic                       flag_space_select_n;
        logic [`DPMC_ADDR_W-1:0]    word_location;
        logic [`DPMC_DATA_W-1:0]    byte_lines;
        logic                       byte_lines_oe;
    } dpmc_pins_t;

    typedef enum logic [3:0] {
        DPMC_IDLE   = 4'h1,
        DPMC_SETUP  = 4'h2,
        DPMC_STROBE = 4'h4,
        DPMC_DONE   = 4'h8
    } dpmc_state_t;

endpackage : dpmc_pkg

// [rtl/dpmc_sync.sv]
// Purpose: Two-flop synchroniser for pin inputs
// Assumes: Single core clock
// Notes:   First stage is read only by the second
`timescale 1ns/1ns
module dpmc_sync #(
    parameter int W = 8
) (
    // Clock and reset
    input  wire logic           core_clk_i,
    input  wire logic           rst_n_i,
    input  wire logic           ce_i,
    // Data
    input  wire logic [W-1:0]   d_i,
    output logic      [W-1:0]   q_o
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_reg <= '0;
            q_o      <= '0;
        end else if (ce_i) begin
            meta_reg <= d_i;
            q_o      <= meta_reg;
        end
    end
endmodule : dpmc_sync

// [sim/dpmc_dev_model.sv]
// Purpose: Behavioural model of one memory port with lock flags
// Assumes: Pins arrive as the host's pin bundle
// Notes:   Released byte lines show a toggling pattern
`timescale 1ns/1ns
`include "dpmc_params.svh"
module dpmc_dev_model (
    input  wire dpmc_pkg::dpmc_pins_t   pins_i,
    output logic [`DPMC_DATA_W-1:0]     byte_lines_o,
    output logic                        collision_wait_n_o,
    output logic                        port_message_flag_n_o
);
    logic [`DPMC_DATA_W-1:0] mem [0:8191];
    logic [7:0]              flags = 8'hFF;
    logic [7:0]              flt   = 8'h5A;
    wire [12:0] loc    = pins_i.word_location;
    wire        ps_n   = pins_i.port_select_n;
    wire        fs_n   = pins_i.flag_space_select_n;
    wire        rw     = pins_i.read_write_select;
    wire        mem_rd = !ps_n && rw && !pins_i.output_drive_enable_n && fs_n;
    wire        flg_rd = ps_n && rw && !pins_i.output_drive_enable_n && !fs_n;
    always #100 flt = ~flt;
    always @* if (!ps_n && !rw && fs_n) mem[loc] = pins_i.byte_lines;
    always @(posedge pins_i.read_write_select)
        if (ps_n && !fs_n) flags[loc[2:0]] = pins_i.byte_lines[0];
    assign byte_lines_o = pins_i.byte_lines_oe ? pins_i.byte_lines : mem_rd ? mem[loc] :
                          flg_rd ? {8{flags[loc[2:0]]}} : flt;
    assign collision_wait_n_o    = 1'h1;
    assign port_message_flag_n_o = 1'h1;
endmodule : dpmc_dev_model

// [sim/dpmc_host_properties.sv]
// Purpose: Pin-level checks for the memory host controller
// Assumes: One core clock, active-low reset
// Notes:   Bound to dpmc_host
`timescale 1ns/1ns
`include "dpmc_params.svh"
module dpmc_host_properties (
    // Clock and user side
    input wire logic                    core_clk_i,
    input wire logic                    nrst_i,
    input wire logic                    ce_i,
    input wire logic                    req_valid_i,
    input wire dpmc_pkg::dpmc_req_t     req_i,
    input wire logic                    req_ready_o,
    input wire logic                    rsp_valid_o,
    input wire logic [`DPMC_DATA_W-1:0] rsp_data_o,
    // Device side
    input wire dpmc_pkg::dpmc_pins_t    pins_o,
    input wire logic [`DPMC_DATA_W-1:0] byte_lines_i,
    input wire logic                    collision_wait_n_i,
    input wire logic                    port_message_flag_n_i,
    input wire logic                    collision_wait_n_o,
    input wire logic                    msg_flag_n_o
);
    default clocking @(posedge core_clk_i); endclocking
    // Frozen cycles stretch all timing, so checks pause while enable is low
    default disable iff (!nrst_i || !ce_i);
    wire take = ce_i && req_valid_i && req_ready_o;
    wire oe_n = pins_o.output_drive_enable_n;
    wire hoe  = pins_o.byte_lines_oe;
    wire ps_n = pins_o.port_select_n;
    wire fs_n = pins_o.flag_space_select_n;
    wire rw   = pins_o.read_write_select;

    no_dual_sel_a: assert property (ps_n || fs_n)
        else $error("port and flag select low together");
    rsp_time_a: assert property (take |-> ##4 rsp_valid_o)
        else $error("response not four cycles after request");
    rsp_pulse_a: assert property (rsp_valid_o |=> !rsp_valid_o)
        else $error("response longer than one cycle");
    wr_drive_a: assert property (!ps_n && !rw |-> pins_o.byte_lines_oe && fs_n)
        else $error("memory write without driven byte lines");
    rd_release_a: assert property (!oe_n |-> !hoe && rw)
        else $error("host drives byte lines during read");
    flag_rise_a: assert property (!fs_n && !rw |=> rw && !fs_n && ps_n)
        else $error("flag write strobe does not rise under flag select");
    flag_loc_a: assert property (take && req_i.op[1] |->
        ##2 pins_o.word_location[2:0] == $past(req_i.addr[2:0], 2))
        else $error("flag index differs from request");
    flag_bit_a: assert property (take && req_i.op == `DPMC_OP_FLAG_WR |->
        ##2 pins_o.byte_lines[0] == $past(req_i.wdata[0], 2))
        else $error("flag write bit differs from request");

    cover property (take && req_i.op == `DPMC_OP_FLAG_WR);
    cover property (!ps_n && rw && !pins_o.output_drive_enable_n);
    cover property (rsp_valid_o);
endmodule : dpmc_host_properties

bind dpmc_host dpmc_host_properties u_dpmc_host_properties (.core_clk_i(core_clk_i),
    .nrst_i(nrst_i), .ce_i(ce_i), .req_valid_i(req_valid_i), .req_i(req_i),
    .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o),
    .pins_o(pins_o), .byte_lines_i(byte_lines_i), .collision_wait_n_i(collision_wait_n_i),
    .port_message_flag_n_i(port_message_flag_n_i), .collision_wait_n_o(collision_wait_n_o),
    .msg_flag_n_o(msg_flag_n_o));

// [sim/test_dpmc_host.sv]
// Purpose: Self-checking bench for the memory host controller
// Assumes: Inputs change on the falling clock edge
// Notes:   Device port is a behavioural model
`timescale 1ns/1ns
`include "dpmc_params.svh"
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin n_errors++; \
    $display("wrong value at %0t: got %h expected %h", $time, a, e); end end
module test_dpmc_host;
    logic                    core_clk_i = 1'h0;
    logic                    nrst_i = 1'h0;
    logic                    ce_i = 1'h1;
    logic                    req_valid_i = 1'h0;
    dpmc_pkg::dpmc_req_t     req_i = '0;
    logic                    req_ready_o, rsp_valid_o, cw_n, mf_n, cw_n_o, mf_n_o;
    logic [`DPMC_DATA_W-1:0] rsp_data_o, byte_lines_i, got;
    dpmc_pkg::dpmc_pins_t    pins_o;
    int                      n_errors = 0, num_checks = 0;
    initial forever #50 core_clk_i = ~core_clk_i;

    dpmc_host u_dpmc_host (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .ce_i(ce_i),
        .req_valid_i(req_valid_i), .req_i(req_i), .req_ready_o(req_ready_o),
        .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o), .pins_o(pins_o),
        .byte_lines_i(byte_lines_i), .collision_wait_n_i(cw_n), .port_message_flag_n_i(mf_n),
        .collision_wait_n_o(cw_n_o), .msg_flag_n_o(mf_n_o));
    dpmc_dev_model u_dpmc_dev_model (.pins_i(pins_o), .byte_lines_o(byte_lines_i),
        .collision_wait_n_o(cw_n), .port_message_flag_n_o(mf_n));

    task automatic do_op(input logic [1:0] op, input logic [12:0] a, input logic [7:0] d);
        int i;
        i = 0;
        while (req_ready_o !== 1'b1 && i < 20) begin @(negedge core_clk_i); i++; end
        req_i = '{op, a, d};
        req_valid_i = 1'h1;
        @(negedge core_clk_i);
        req_valid_i = 1'h0;
        i = 0;
        while (rsp_valid_o !== 1'b1 && i < 20) begin @(negedge core_clk_i); i++; end
        `CHK(rsp_valid_o, 1'b1)
        got = rsp_data_o;
        @(negedge core_clk_i);
    endtask : do_op

    task automatic t_reset;
        repeat (4) @(negedge core_clk_i);
        `CHK(pins_o.port_select_n, 1'b1)
        `CHK(pins_o.flag_space_select_n, 1'b1)
        `CHK(pins_o.byte_lines_oe, 1'b0)
        `CHK({cw_n_o, mf_n_o}, 2'h3)
        `CHK(req_ready_o, 1'b1)
        $display("test reset done");
    endtask : t_reset

    task automatic t_mem;
        logic [12:0] la [3] = '{13'h0000, 13'h1FFF, 13'h0AAA};
        logic [7:0]  da [3] = '{8'h96, 8'h3C, 8'hE1};
        for (int k = 0; k < 3; k++) do_op(`DPMC_OP_WRITE, la[k], da[k]);
        for (int k = 0; k < 3; k++) begin
            do_op(`DPMC_OP_READ, la[k], 8'h00);
            `CHK(got, da[k])
        end
        $display("test memory done");
    endtask : t_mem

    task automatic t_flag;
        for (int k = 0; k < 8; k++) do_op(`DPMC_OP_FLAG_WR, 13'h1FF8 | k, {{7{~k[0]}}, k[0]});
        for (int k = 0; k < 8; k++) begin
            do_op(`DPMC_OP_FLAG_RD, 13'(k), 8'h00);
            `CHK(got, {8{k[0]}})
        end
        do_op(`DPMC_OP_READ, 13'h0000, 8'h00);
        `CHK(got, 8'h96)
        $display("test flags done");
    endtask : t_flag

    task automatic t_hold;
        dpmc_pkg::dpmc_pins_t held;
        `CHK(req_ready_o, 1'b1)
        req_i = '{`DPMC_OP_WRITE, 13'h0155, 8'h69};
        req_valid_i = 1'h1;
        @(negedge core_clk_i);
        req_valid_i = 1'h0;
        ce_i = 1'h0;
        held = pins_o;
        repeat (3) @(negedge core_clk_i);
        `CHK(pins_o, held)
        `CHK({req_ready_o, rsp_valid_o}, 2'h0)
        ce_i = 1'h1;
        repeat (3) @(negedge core_clk_i);
        `CHK({rsp_valid_o, rsp_data_o}, 9'h100)
        @(negedge core_clk_i);
        do_op(`DPMC_OP_READ, 13'h0155, 8'h00);
        `CHK(got, 8'h69)
        // Reset in the middle of a read
        req_i = '{`DPMC_OP_READ, 13'h0155, 8'h00};
        req_valid_i = 1'h1;
        @(negedge core_clk_i);
        req_valid_i = 1'h0;
        nrst_i = 1'h0;
        #1;
        `CHK({pins_o.port_select_n, pins_o.output_drive_enable_n, req_ready_o}, 3'h6)
        @(negedge core_clk_i);
        nrst_i = 1'h1;
        repeat (3) @(negedge core_clk_i);
        `CHK({req_ready_o, rsp_valid_o, cw_n_o, mf_n_o}, 4'hB)
        do_op(`DPMC_OP_READ, 13'h0155, 8'h00);
        `CHK(got, 8'h69)
        $display("test hold and reset done");
    endtask : t_hold

    task automatic stop_test;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : stop_test

    initial begin
        repeat (3) @(negedge core_clk_i);
        nrst_i = 1'h1;
        t_reset();
        t_mem();
        t_flag();
        t_hold();
        stop_test();
    end
    initial begin
        #100000;
        n_errors++;
        stop_test();
    end
endmodule : test_dpmc_host
